// *** hw/dc_time_params.svh ***
// offsets, reset values and timing counts of the distributed clock time register set
`ifndef DC_TIME_PARAMS_SVH
`define DC_TIME_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses)
`define ADDR_RX_PORT0     12'h900
`define ADDR_RX_PORT1     12'h904
`define ADDR_RX_PORT2     12'h908
`define ADDR_SYS_TIME     12'h910
`define ADDR_RX_PU        12'h918
`define ADDR_TIME_OFFSET  12'h920
`define ADDR_PATH_DELAY   12'h928
`define ADDR_DEVIATION    12'h92c
`define ADDR_SPEED_START  12'h930
`define ADDR_CLOCK_DEV    12'h932
`define ADDR_FILTER_DEPTH 12'h934

// ==========================================================
// reset values
`define RST_SPEED_START   15'h1000
`define RST_FILTER_DEPTH  4'h4

// ==========================================================
// timing
`define CLK_PERIOD_NS     64'd20
`define SPEED_LIMIT_BASE  16'h007f

`endif

// *** hw/dc_time_pkg.sv ***
// types of the distributed clock time register set
package dc_time_pkg;

  // ==========================================================
  // frame phase
  typedef enum logic [0:0] {
    PH_IDLE  = 1'b0,
    PH_FRAME = 1'b1
  } frame_phase_t;

  // ==========================================================
  // byte access from either side
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  data;
  } byte_req_t;

  // ==========================================================
  // frame events from the receive path
  typedef struct packed {
    logic sof;
    logic eof;
    logic pre1;
    logic pre2;
    logic prePu;
  } frame_evt_t;

  // ==========================================================
  // whole block state
  typedef struct packed {
    frame_phase_t phase;
    logic [63:0]  localTime;
    logic [63:0]  offset;
    logic [63:0]  adj;
    logic [31:0]  delay;
    logic [31:0]  pend1;
    logic [31:0]  pend2;
    logic [63:0]  pendPu;
    logic [31:0]  rxPort1;
    logic [31:0]  rxPort2;
    logic [63:0]  rxPu;
    logic         latchHit;
    logic [63:0]  sofTime;
    logic [31:0]  wrTime;
    logic         wrLow;
    logic [63:0]  hostSnap;
    logic         devSign;
    logic [30:0]  devMean;
    logic [14:0]  speedStart;
    logic [15:0]  clockDev;
    logic [3:0]   depth;
    logic [14:0]  loopCnt;
    logic [7:0]   netRdData;
    logic [7:0]   hostRdData;
  } dc_state_t;

endpackage

// *** hw/dc_time_sync.sv ***
// distributed clock time keeping and synchronisation register set
//
// How it works
// R01: latch write to port-0 time latches ports
// R02: port-1 register takes port-1 preamble time
// R03: port-2 register takes port-2 preamble time
// R04: multi-byte registers little endian
// R05: network read returns start-of-frame time plus delay
// R06: host read of low byte snapshots time
// R07: low word write compared, never stored
// R08: compare at frame end if low byte written
// R09: only network writes trigger control loop
// R10: processing unit time kept 64-bit
// R11: port 0 open mirrors port-0 time
// R12: system time is local time plus offset
// R13: 32-bit path delay, resets zero
// R14: deviation bit 31 set when local smaller
// R15: deviation low bits hold mean magnitude
// R16: 15-bit bandwidth setting, reset 1000h
// R17: bandwidth write clears both deviations
// R18: period deviation clamped to start minus 7Fh
// R19: 4-bit filter depth, reset 4h
// R20: filter depth write clears time deviation
// R21: bandwidth bit 15 reads zero
// R22: loop nudges time by deviation sign
`timescale 1ns/1ps
`include "dc_time_params.svh"

module dc_time_sync
  import dc_time_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire byte_req_t   netReq,
  input  wire byte_req_t   hostReq,
  input  wire frame_evt_t  frameEvt,
  input  wire logic        port0Open,
  input  wire logic [31:0] port0RxTime,
  output logic      [7:0]  netRdData,
  output logic      [7:0]  hostRdData
);

  dc_state_t   s;
  dc_state_t   next_s;
  logic [63:0] sysNow;
  logic [31:0] diff;
  logic [31:0] mag;
  logic [30:0] mag31;
  logic [32:0] delta;
  logic [32:0] step;
  logic [15:0] lim;
  logic [15:0] absDev;
  logic [14:0] period;
  logic [2:0]  nb;

  // ==========================================================
  // read side byte select
  function automatic logic [7:0] read_byte(
    input dc_state_t   st,
    input logic [11:0] addr,
    input logic        isNet,
    input logic        p0Open,
    input logic [31:0] p0Time
  );
    logic [63:0] w;
    logic [11:0] base;
    w    = 64'h0;
    base = {addr[11:3], 3'b000};
    if (base == `ADDR_RX_PORT0) begin
      w = {st.rxPort1, p0Time};
    end else if (base == `ADDR_RX_PORT2) begin
      w = {32'h0, st.rxPort2};
    end else if (base == `ADDR_SYS_TIME) begin
      w = isNet ? st.sofTime : st.hostSnap; // see R05
    end else if (base == `ADDR_RX_PU) begin
      w = p0Open ? {32'h0, p0Time} : st.rxPu; // see R11
    end else if (base == `ADDR_TIME_OFFSET) begin
      w = st.offset;
    end else if (base == `ADDR_PATH_DELAY) begin
      w = {st.devSign, st.devMean, st.delay}; // see R14, R15
    end else if (base == `ADDR_SPEED_START) begin
      w = {28'h0, st.depth, st.clockDev, 1'b0, st.speedStart}; // see R19, R21
    end
    read_byte = w[addr[2:0]*8 +: 8]; // see R04
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    sysNow = s.localTime + s.offset + s.adj; // see R12
    diff   = 32'h0;
    mag    = 32'h0;
    mag31  = 31'h0;
    delta  = 33'h0;
    step   = 33'h0;
    lim    = {1'b0, s.speedStart} - `SPEED_LIMIT_BASE;
    absDev = s.clockDev[15] ? 16'(-s.clockDev) : s.clockDev;
    period = s.speedStart - absDev[14:0];
    nb     = netReq.addr[2:0];
    if (ce) begin
      next_s.localTime = s.localTime + `CLK_PERIOD_NS;

      // preamble times held until the frame proves to be a latch frame
      if (frameEvt.pre1) begin
        next_s.pend1 = s.localTime[31:0];
      end
      if (frameEvt.pre2) begin
        next_s.pend2 = s.localTime[31:0];
      end
      if (frameEvt.prePu) begin
        next_s.pendPu = s.localTime;
      end

      // start of frame delimiter
      if (frameEvt.sof) begin
        next_s.phase    = PH_FRAME;
        next_s.sofTime  = sysNow + {32'h0, s.delay}; // see R05
        next_s.latchHit = 1'b0;
        next_s.wrLow    = 1'b0;
      end

      // control loop steering of the time copy
      if (s.loopCnt >= period) begin
        next_s.loopCnt = 15'h0;
        if (s.clockDev != 16'h0) begin
          next_s.adj = s.clockDev[15] ? s.adj - 64'd1 : s.adj + 64'd1; // see R22
        end
      end else begin
        next_s.loopCnt = s.loopCnt + 15'd1;
      end

      // network side writes
      if (netReq.wr) begin
        case ({netReq.addr[11:2], 2'b00})
          `ADDR_RX_PORT0: begin
            next_s.latchHit = 1'b1; // see R01
          end
          `ADDR_SYS_TIME: begin
            next_s.wrTime[nb[1:0]*8 +: 8] = netReq.data; // see R07
            if (nb[1:0] == 2'b00) begin
              next_s.wrLow = 1'b1; // see R08, R09
            end
          end
          `ADDR_TIME_OFFSET, `ADDR_TIME_OFFSET + 12'h4: begin
            next_s.offset[nb*8 +: 8] = netReq.data; // see R12
          end
          `ADDR_PATH_DELAY: begin
            next_s.delay[nb[1:0]*8 +: 8] = netReq.data; // see R13
          end
          `ADDR_SPEED_START: begin
            if (nb[1:0] == 2'b00) begin
              next_s.speedStart[7:0] = netReq.data; // see R16
            end else if (nb[1:0] == 2'b01) begin
              next_s.speedStart[14:8] = netReq.data[6:0]; // see R21
            end
            if (!nb[1]) begin
              next_s.devSign  = 1'b0; // see R17
              next_s.devMean  = 31'h0;
              next_s.clockDev = 16'h0;
            end
          end
          `ADDR_FILTER_DEPTH: begin
            if (nb[1:0] == 2'b00) begin
              next_s.depth   = netReq.data[3:0]; // see R19
              next_s.devSign = 1'b0; // see R20
              next_s.devMean = 31'h0;
            end
          end
          default: begin
          end
        endcase
      end

      // end of frame: commit latches and run the compare
      if (frameEvt.eof) begin
        next_s.phase = PH_IDLE;
        if (next_s.latchHit) begin
          next_s.rxPort1 = s.pend1; // see R02
          next_s.rxPort2 = s.pend2; // see R03
          next_s.rxPu    = s.pendPu; // see R10
        end
        if (next_s.wrLow) begin
          diff  = s.sofTime[31:0] - next_s.wrTime; // see R08
          mag   = diff[31] ? 32'(-diff) : diff;
          mag31 = mag[31] ? 31'h7fffffff : mag[30:0];
          delta = {2'b00, mag31} - {2'b00, next_s.devMean};
          step  = $signed(delta) >>> s.depth; // see R19
          next_s.devMean = next_s.devMean + step[30:0]; // see R15
          next_s.devSign = diff[31]; // see R14
          if (diff[31]) begin
            if ($signed(next_s.clockDev) < $signed(lim)) begin
              next_s.clockDev = next_s.clockDev + 16'd1; // see R18
            end
          end else if (mag != 32'h0) begin
            if ($signed(next_s.clockDev) > $signed(16'(-lim))) begin
              next_s.clockDev = next_s.clockDev - 16'd1; // see R18
            end
          end
          next_s.wrLow = 1'b0;
        end
      end

      // read data, both sides
      if (netReq.rd) begin
        next_s.netRdData = read_byte(s, netReq.addr, 1'b1, port0Open, port0RxTime);
      end
      if (hostReq.rd) begin
        if (hostReq.addr == `ADDR_SYS_TIME) begin
          next_s.hostSnap   = sysNow; // see R06
          next_s.hostRdData = sysNow[7:0];
        end else begin
          next_s.hostRdData = read_byte(s, hostReq.addr, 1'b0, port0Open, port0RxTime);
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s            <= '0;
      s.speedStart <= `RST_SPEED_START; // see R16
      s.depth      <= `RST_FILTER_DEPTH;
    end else begin
      s <= next_s;
    end
  end

  assign netRdData  = s.netRdData;
  assign hostRdData = s.hostRdData;

endmodule

// *** sim/dc_time_sync_assertions.sv ***
// checker of the time register set ports
`timescale 1ns/1ps
module dc_time_sync_checker
  import dc_time_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ce,
  input wire byte_req_t   netReq,
  input wire byte_req_t   hostReq,
  input wire frame_evt_t  frameEvt,
  input wire logic        port0Open,
  input wire logic [31:0] port0RxTime,
  input wire logic [7:0]  netRdData,
  input wire logic [7:0]  hostRdData
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire        nRd = ce & netReq.rd;
  wire        hRd = ce & hostReq.rd;
  wire        nWr = ce & netReq.wr & ~frameEvt.eof;
  wire [11:0] nA  = netReq.addr;
  wire [11:0] hA  = hostReq.addr;
  // ==========================================================
  // assertions
  property p_puLow;
    hRd & port0Open & hA == 12'h918 |=> hostRdData == $past(port0RxTime[7:0]);
  endproperty
  a_puLow: assert property (p_puLow) else $error("pu low byte wrong");
  property p_puHigh;
    hRd & port0Open & hA[11:2] == 10'h247 |=> hostRdData == 8'h00;
  endproperty
  a_puHigh: assert property (p_puHigh) else $error("pu high byte wrong");
  property p_startTop;
    nRd & nA == 12'h931 |=> !netRdData[7];
  endproperty
  a_startTop: assert property (p_startTop) else $error("start bit 15 set");
  property p_depthTop;
    hRd & hA == 12'h934 |=> hostRdData[7:4] == 4'h0;
  endproperty
  a_depthTop: assert property (p_depthTop) else $error("depth top bits set");
  property p_speedClr;
    nWr & nA == 12'h930 ##1 nRd & nA == 12'h932 |=> netRdData == 8'h00;
  endproperty
  a_speedClr: assert property (p_speedClr) else $error("period dev kept");
  property p_devClr;
    nWr & nA == 12'h931 ##1 nRd & nA == 12'h92f |=> netRdData == 8'h00;
  endproperty
  a_devClr: assert property (p_devClr) else $error("deviation kept");
  property p_depthClr;
    nWr & nA == 12'h934 ##1 nRd & nA == 12'h92f |=> netRdData == 8'h00;
  endproperty
  a_depthClr: assert property (p_depthClr) else $error("deviation kept");
  property p_delayRw;
    nWr & nA == 12'h928 ##1 hRd & hA == 12'h928 |=> hostRdData == $past(netReq.data, 2);
  endproperty
  a_delayRw: assert property (p_delayRw) else $error("delay not stored");
  c_frame: cover property (frameEvt.eof);
  c_sysWr: cover property (nWr & nA == 12'h910);
  c_puRd: cover property (hRd & port0Open);
endmodule

bind dc_time_sync dc_time_sync_checker chk (.mclk, .reset, .ce, .netReq, .hostReq,
  .frameEvt, .port0Open, .port0RxTime, .netRdData, .hostRdData);

// *** sim/net_master.sv ***
// network master model driving frame events and byte accesses
`timescale 1ns/1ps
module net_master
  import dc_time_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] netRdData,
  output byte_req_t       netReq,
  output frame_evt_t      frameEvt
);
  initial begin
    netReq   = '0;
    frameEvt = '0;
  end
  // one byte per cycle, request held until the next call
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    netReq   = '{w, !w, a, (a == 12'h931) ? d & 8'h7f : d};
    frameEvt = '0;
    @(negedge mclk);
    q = netRdData;
  endtask
  // released lines show inverted values
  task automatic evt(input frame_evt_t e);
    netReq   = '{1'b0, 1'b0, ~netReq.addr, ~netReq.data};
    frameEvt = e;
    @(negedge mclk);
  endtask
  task automatic frame(input int gap, input logic [31:0] v);
    logic [7:0] q;
    evt(5'b00101);
    repeat (gap) evt(5'b00000);
    evt(5'b00010);
    evt(5'b10000);
    acc(1'b1, 12'h900, 8'h00, q);
    for (int i = 0; i < 4; i++) acc(1'b1, 12'h910 + 12'(i), v[8*i +: 8], q);
    evt(5'b01000);
    evt(5'b00000);
  endtask
endmodule

// *** sim/distributed_clock_time_sync_tb_top.sv ***
// self-checking bench of the time register set
`timescale 1ns/1ps
module distributed_clock_time_sync_tb_top
  import dc_time_pkg::*;
;
  logic        mclk;
  logic        reset;
  logic        ce;
  byte_req_t   netReq;
  byte_req_t   hostReq;
  frame_evt_t  frameEvt;
  logic        port0Open;
  logic [31:0] port0RxTime;
  logic [7:0]  netRdData;
  logic [7:0]  hostRdData;
  int          errors;
  int          compares;

  always #10 mclk = ~mclk;

  dc_time_sync dut (.mclk, .reset, .ce, .netReq, .hostReq, .frameEvt, .port0Open,
    .port0RxTime, .netRdData, .hostRdData);
  net_master m (.mclk, .netRdData, .netReq, .frameEvt);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic host, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    if (host) begin
      hostReq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge mclk);
      q = hostRdData;
    end else begin
      hostReq.rd = 1'b0;
      m.acc(1'b0, a, 8'h00, q);
    end
    chk({24'h0, q}, {24'h0, e});
  endtask
  task automatic hrd(input logic [11:0] a, output logic [7:0] q);
    hostReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    q = hostRdData;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    m.acc(1'b1, a, d, q);
  endtask
  task automatic rd32(input logic [11:0] a, output logic [31:0] v);
    logic [7:0] q;
    for (int i = 0; i < 4; i++) begin
      m.acc(1'b0, a + 12'(i), 8'h00, q);
      v[8*i +: 8] = q;
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog, far beyond the fewer than 170 cycles of the run
  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    logic [31:0] v;
    logic [31:0] t1;
    logic [31:0] t2;
    logic [63:0] w;
    int          g;
    int          s;
    mclk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    hostReq = '0;
    port0Open = 1'b0;
    port0RxTime = 32'h0;
    errors = 0;
    compares = 0;
    void'($urandom(90));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    rdc(1'b0, 12'h931, 8'h10);
    rdc(1'b1, 12'h934, 8'h04);
    for (int i = 0; i < 8; i++) rdc(1'b1, 12'h928 + 12'(i), 8'h00);
    v = $urandom & 32'h0000ffff;
    for (int i = 3; i >= 0; i--) wr(12'h928 + 12'(i), v[8*i +: 8]);
    for (int i = 0; i < 4; i++) rdc(1'b1, 12'h928 + 12'(i), v[8*i +: 8]);
    w = {$urandom, 32'h0};
    for (int i = 7; i >= 0; i--) wr(12'h920 + 12'(i), w[8*i +: 8]);
    for (int i = 4; i < 8; i++) rdc(1'b0, 12'h920 + 12'(i), w[8*i +: 8]);
    hostReq = '{1'b1, 1'b0, 12'h928, ~v[7:0]};
    @(negedge mclk);
    rdc(1'b1, 12'h928, v[7:0]);
    s = 'h80 + $urandom_range(16'h3f7f);
    wr(12'h930, s[7:0]);
    wr(12'h931, s[15:8] | 8'h80);
    rdc(1'b0, 12'h931, s[15:8]);
    ce = 1'b0;
    rdc(1'b0, 12'h930, s[15:8]);
    ce = 1'b1;
    for (int k = 0; k < 2; k++) begin
      g = 1 + $urandom_range(7);
      m.frame(g, k ? 32'h0 : 32'h70000000);
      rd32(12'h904, t1);
      rd32(12'h908, t2);
      chk(t2 - t1, 32'(20 * (g + 1)));
      rd32(12'h918, t2);
      chk(t2, t1);
      rd32(12'h92c, t1);
      chk(32'(t1[31]), 32'(k == 0));
      rdc(1'b0, 12'h933, k ? 8'hff : 8'h00);
      rdc(1'b0, 12'h932, k ? 8'hff : 8'h01);
      if (k == 0) begin
        wr(12'h934, 8'hff);
        rdc(1'b0, 12'h92f, 8'h00);
        rdc(1'b0, 12'h934, 8'h0f);
        wr(12'h930, s[7:0]);
        rdc(1'b0, 12'h932, 8'h00);
        wr(12'h931, s[15:8]);
        rdc(1'b0, 12'h92f, 8'h00);
      end
    end
    for (int i = 0; i < 8; i++) hrd(12'h910 + 12'(i), w[8*i +: 8]);
    repeat (20) @(negedge mclk);
    for (int i = 1; i < 8; i++) rdc(1'b1, 12'h910 + 12'(i), w[8*i +: 8]);
    port0Open = 1'b1;
    port0RxTime = $urandom;
    for (int i = 0; i < 8; i++)
      rdc(1'b1, 12'h918 + 12'(i), i < 4 ? port0RxTime[8*i +: 8] : 8'h00);
    close_out();
  end
endmodule
